// File: verification/pcs_bus_master.sv
`include "pcs_consts.svh"
// ==========================================================================
// bus master model: bit clock, frame sync, mode straps and slot data
module pcs_bus_master
  import pcs_pkg::*;
(
  // control from the bench
  input wire logic [1:0] mode_sel,
  input wire logic b2,
  input wire logic long_fs,
  input wire logic sync_en,
  input wire logic [7:0] rx_word,
  // link pins
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic serial_rx_data,
  input wire logic serial_tx_data,
  input wire logic serial_tx_oe_n,
  // what the transmit pin showed in the last frame
  output logic [7:0] tx_word,
  output logic [5:0] lo_frame,
  output logic [7:0] frame_no
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME_BITS = 48; // keeps 40 or more clocks between frames
  logic [5:0] bc_q = 6'h00;
  logic [5:0] lo_q = 6'h00;
  logic [7:0] word_q = 8'h00;
  logic [7:0] sh_q = 8'h00;
  logic fs_q = 1'b0;

  // first bit clock of the active slot, b1 always at the frame edge
  function automatic int slot_start();
    if (mode_sel == PCS_MODE_PCM || !b2)
      return 0;
    if (mode_sel == PCS_MODE_GCI)
      return int'(`PCS_SLOT_GCI_B2);
    return int'(`PCS_SLOT_IDL_B2);
  endfunction : slot_start

  // bit clock runs free; half-ns offset keeps it off the bench's edges
  initial
  begin
    tx_word = 8'h00;
    lo_frame = 6'h00;
    frame_no = 8'h00;
    serial_rx_data = 1'b1;
    tx_bit_clock = 1'b0;
    #7.5;
    forever #15 tx_bit_clock = ~tx_bit_clock;
  end

  // pcm: receive clock toggles; isdn: strap held low or high, sync is b2
  assign rx_bit_clock = (mode_sel == PCS_MODE_PCM) ? tx_bit_clock :
    (mode_sel == PCS_MODE_IDL);
  assign rx_frame_sync = (mode_sel == PCS_MODE_PCM) ? fs_q : b2;
  assign tx_frame_sync = fs_q;

  // sync and receive data change just after the rising edge
  always @(posedge tx_bit_clock)
  begin : drive
    int n;
    int k;
    n = (bc_q == 6'(FRAME_BITS - 1)) ? 0 : int'(bc_q) + 1;
    bc_q <= 6'(n);
    fs_q <= sync_en && (n == 0 || (long_fs && n < 3));
    if (n == 0)
      word_q <= rx_word;
    k = n - slot_start() - 1;
    if (mode_sel == PCS_MODE_GCI)
      k = (k < 0) ? -1 : k / 2; // gci bits last two clocks
    // outside the slot the line never holds its last bit
    if (k >= 0 && k < 8)
      serial_rx_data <= word_q[7 - k];
    else
      serial_rx_data <= ~serial_rx_data;
  end

  // transmit bits taken on falling edges, gci on the second of each bit
  always @(negedge tx_bit_clock)
  begin : sample
    int k;
    k = int'(bc_q) - slot_start() - 1;
    if (mode_sel == PCS_MODE_GCI)
      k = (k < 0 || k % 2 == 0) ? -1 : k / 2;
    if (k >= 0 && k < 8)
      sh_q[7 - k] <= serial_tx_oe_n ? ~serial_tx_data : serial_tx_data;
    if (bc_q == 6'(FRAME_BITS - 1))
    begin
      tx_word <= sh_q;
      lo_frame <= lo_q;
      lo_q <= 6'h00;
      frame_no <= frame_no + 8'h01;
    end
    else if (serial_tx_oe_n == 1'b0)
      lo_q <= lo_q + 6'h01;
  end
endmodule : pcs_bus_master

// File: verification/tb_top.sv
// ==========================================================================
// bench top: codec serial block against the bus master model
module tb_top
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOSS = 400; // short loss timeout, a frame is 180 cycles
  localparam int PERIOD = 180; // 48 bit clocks of 30 ns in 8 ns cycles
  localparam int CYC_MAX = 30000;
  localparam logic [15:0] VIN [6] = '{16'h0000, 16'h7fff, 16'h8000,
    16'h0000, 16'h7fff, 16'h8000};
  localparam logic [7:0] VCODE [6] = '{8'hff, 8'h80, 8'h00,
    8'hd5, 8'haa, 8'h2a};
  localparam logic [15:0] VLIN [6] = '{16'h0000, 16'h7d7c, 16'h8284,
    16'h0008, 16'h7e00, 16'h8200};
  logic clk_sys = 1'b0;
  logic rst_n, mu_law_select, power_up;
  logic [15:0] tx_sample, rx_sample, frame_period;
  logic tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync;
  logic serial_rx_data, serial_tx_data, serial_tx_oe_n;
  logic sample_strobe, active_b2, standby, long_frame;
  pcs_mode_t mode;
  logic [1:0] mode_sel;
  logic b2, long_fs, sync_en;
  logic [7:0] rx_word, tx_word, frame_no;
  logic [5:0] lo_frame;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int strobe_cnt = 0;

  always #4 clk_sys = ~clk_sys;

  // ==========================================================================
  // design and far side
  pcs_codec_serial #(.FRAME_LOSS_CYC(LOSS)) i_pcs_codec_serial (
    .clk_sys(clk_sys), .rst_n(rst_n), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .serial_rx_data(serial_rx_data),
    .serial_tx_data(serial_tx_data), .serial_tx_oe_n(serial_tx_oe_n),
    .mu_law_select(mu_law_select), .power_up(power_up),
    .tx_sample(tx_sample), .sample_strobe(sample_strobe),
    .rx_sample(rx_sample), .frame_period(frame_period), .mode(mode),
    .active_b2(active_b2), .standby(standby), .long_frame(long_frame));
  pcs_bus_master i_pcs_bus_master (
    .mode_sel(mode_sel), .b2(b2), .long_fs(long_fs), .sync_en(sync_en),
    .rx_word(rx_word), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock),
    .rx_frame_sync(rx_frame_sync), .serial_rx_data(serial_rx_data),
    .serial_tx_data(serial_tx_data), .serial_tx_oe_n(serial_tx_oe_n),
    .tx_word(tx_word), .lo_frame(lo_frame), .frame_no(frame_no));

  // ==========================================================================
  // compares, waits and the verdict
  task automatic check_bit(input string what, input logic exp, got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // frame ends come from the model; inputs change just after a clock edge
  task automatic wait_frames(input int n);
    repeat (n)
      @(frame_no);
    @(posedge clk_sys);
    #1;
  endtask : wait_frames

  // one word each way; transmit has one frame of latency
  task automatic run_vec(input int i, input int exp_lo);
    mu_law_select = (i < 3);
    tx_sample = VIN[i];
    rx_word = VCODE[i];
    wait_frames(3);
    check_word("tx_code", 16'(VCODE[i]), 16'(tx_word));
    check_word("tx_drive", 16'(exp_lo), 16'(lo_frame));
    check_word("rx_sample", VLIN[i], rx_sample);
  endtask : run_vec

  // transmit pin stays released for two frames after power-up or after sync returns
  task automatic guard_check();
    repeat (2)
    begin
      wait_frames(1);
      check_word("guard_drive", 16'h0000, 16'(lo_frame));
    end
    wait_frames(3);
    check_word("drive_after", 16'h0008, 16'(lo_frame));
    check_bit("standby", 1'b0, standby);
  endtask : guard_check

  // ==========================================================================
  // scenarios
  task automatic test_codec();
    for (int i = 0; i < 6; i++)
      run_vec(i, 8);
    strobe_cnt = 0;
    wait_frames(3);
    check_word("strobes", 16'h0003, 16'(strobe_cnt));
    check_bit("period", 1'b1,
      frame_period inside {[PERIOD - 1:PERIOD + 1]});
    check_bit("long_frame", 1'b0, long_frame);
    $display("test codec done");
  endtask : test_codec

  task automatic test_long();
    long_fs = 1'b1;
    run_vec(1, 8);
    check_bit("long_frame", 1'b1, long_frame);
    long_fs = 1'b0;
    wait_frames(2);
    check_bit("long_frame", 1'b0, long_frame);
    $display("test long frame done");
  endtask : test_long

  task automatic test_modes();
    pcs_mode_t m [5] = '{PCS_MODE_GCI, PCS_MODE_GCI, PCS_MODE_IDL,
      PCS_MODE_IDL, PCS_MODE_PCM};
    logic sel [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int lo [5] = '{16, 16, 8, 8, 8};
    for (int j = 0; j < 5; j++)
    begin
      mode_sel = m[j];
      b2 = sel[j];
      wait_frames(1);
      if (j == 0)
        check_word("mode_early", 16'h0000, 16'(mode));
      wait_frames(4);
      check_word("mode", 16'(m[j]), 16'(mode));
      if (j < 4)
        check_bit("active_b2", sel[j], active_b2);
      run_vec(j, lo[j]);
    end
    $display("test modes done");
  endtask : test_modes

  task automatic test_standby();
    sync_en = 1'b0;
    repeat (LOSS + 300)
      @(posedge clk_sys);
    wait_frames(1);
    check_bit("standby", 1'b1, standby);
    check_bit("oe_n_idle", 1'b1, serial_tx_oe_n);
    sync_en = 1'b1;
    guard_check();
    $display("test standby done");
  endtask : test_standby

  task automatic test_power();
    power_up = 1'b0;
    wait_frames(2);
    check_word("off_drive", 16'h0000, 16'(lo_frame));
    power_up = 1'b1;
    guard_check();
    $display("test power done");
  endtask : test_power

  // strobe count and a cycle ceiling against a hang
  always @(posedge clk_sys)
  begin
    cyc++;
    if (sample_strobe === 1'b1)
      strobe_cnt++;
    if (cyc == CYC_MAX)
    begin
      error_cnt++;
      $display("MISMATCH cycle_limit expected %0d seen %0d", CYC_MAX - 1, cyc);
      test_done();
    end
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    mu_law_select = 1'b1;
    power_up = 1'b1;
    tx_sample = 16'h0000;
    mode_sel = PCS_MODE_PCM;
    b2 = 1'b0;
    long_fs = 1'b0;
    sync_en = 1'b0;
    rx_word = 8'hff;
    repeat (8)
      @(posedge clk_sys);
    #1;
    check_bit("standby_reset", 1'b1, standby);
    check_bit("oe_n_reset", 1'b1, serial_tx_oe_n);
    rst_n = 1'b1;
    repeat (20)
      @(posedge clk_sys);
    #1;
    sync_en = 1'b1;
    wait_frames(4);
    test_codec();
    test_long();
    test_modes();
    test_standby();
    test_power();
    test_done();
  end
endmodule : tb_top

// File: verilog/pcs_codec_serial.sv
// What this block does
// - law pin high selects mu-law, low selects a-law.
// - each transmit sample is compressed into one 8-bit code word.
// - one compressed word goes out serially per transmit frame.
// - received bits are shifted in, then expanded once per frame.
// - expander and compressor share the same law pin.
// - toggling receive bit clock with 8 kHz sync means long/short mode.
// - receive bit clock held low means GCI; sync pin picks B1/B2.
// - receive bit clock held high means IDL; sync pin picks B1/B2.
// - data in only on serial_rx_data, out only on serial_tx_data.
// - internal sample strobe and rate are locked to the frame sync.
// - sync high on two falling edges is long, on one is short.
// - transmit pin stays released for two frames after power-up.
// - GCI only after the strap is low for three or more frames.
`include "pcs_consts.svh"
module pcs_codec_serial
  import pcs_pkg::*;
#(
  parameter int FRAME_LOSS_CYC = `PCS_FRAME_LOSS_CYC
)
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic serial_rx_data,
  output logic serial_tx_data,
  output logic serial_tx_oe_n,
  // straps
  input wire logic mu_law_select,
  input wire logic power_up,
  // converter side
  input wire logic [15:0] tx_sample,
  output logic sample_strobe,
  output logic [15:0] rx_sample,
  output logic [15:0] frame_period,
  // status
  output pcs_mode_t mode,
  output logic active_b2,
  output logic standby,
  output logic long_frame
);
  // ========================================================================
  // pin synchronisers into the system domain
  logic law_s1_q, law_s2_q, pwr_s1_q, pwr_s2_q;
  logic rbc_s1_q, rbc_s2_q, rfs_s1_q, rfs_s2_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic frame_tgl_q;
  logic frame_evt;

  // straps and the frame toggle pass two flops before any use
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      {law_s1_q, law_s2_q, pwr_s1_q, pwr_s2_q} <= 4'h0;
      {rbc_s1_q, rbc_s2_q, rfs_s1_q, rfs_s2_q} <= 4'h0;
      {tgl_s1_q, tgl_s2_q, tgl_s3_q} <= 3'h0;
    end
    else
    begin
      {law_s2_q, law_s1_q} <= {law_s1_q, mu_law_select};
      {pwr_s2_q, pwr_s1_q} <= {pwr_s1_q, power_up};
      {rbc_s2_q, rbc_s1_q} <= {rbc_s1_q, rx_bit_clock};
      {rfs_s2_q, rfs_s1_q} <= {rfs_s1_q, rx_frame_sync};
      {tgl_s3_q, tgl_s2_q, tgl_s1_q} <= {tgl_s2_q, tgl_s1_q, frame_tgl_q};
    end

  assign frame_evt = tgl_s2_q ^ tgl_s3_q;

  // ========================================================================
  // pre-scaler: frame period measure, sample strobe, loss of sync
  logic [15:0] per_cnt_q, frame_period_q;
  logic sample_strobe_q, standby_q;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      per_cnt_q <= 16'h0000;
      frame_period_q <= 16'h0000;
      sample_strobe_q <= 1'b0;
      standby_q <= 1'b1;
    end
    else
    begin
      sample_strobe_q <= frame_evt;
      if (frame_evt)
      begin
        frame_period_q <= per_cnt_q;
        per_cnt_q <= 16'h0000;
        standby_q <= 1'b0;
      end
      else if (per_cnt_q >= 16'(FRAME_LOSS_CYC))
        standby_q <= 1'b1; // sync gone FRAME_LOSS_CYC cycles: low power standby
      else
        per_cnt_q <= per_cnt_q + 16'h0001;
    end

  // ========================================================================
  // strap watch: a receive bit clock that never moves for whole frames
  logic rbc_prev_q, rbc_seen_q;
  logic [1:0] low_frames_q, high_frames_q;
  pcs_mode_t mode_q;
  logic active_b2_q;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rbc_prev_q <= 1'b0;
      rbc_seen_q <= 1'b0;
      low_frames_q <= 2'd0;
      high_frames_q <= 2'd0;
      mode_q <= PCS_MODE_PCM;
      active_b2_q <= 1'b0;
    end
    else
    begin
      rbc_prev_q <= rbc_s2_q;
      // a toggle in the frame cycle itself still counts, for the next frame
      if (frame_evt)
        rbc_seen_q <= rbc_s2_q != rbc_prev_q;
      else if (rbc_s2_q != rbc_prev_q)
        rbc_seen_q <= 1'b1;
      if (frame_evt)
      begin
        active_b2_q <= rfs_s2_q;
        if (rbc_seen_q)
        begin
          low_frames_q <= 2'd0;
          high_frames_q <= 2'd0;
          mode_q <= PCS_MODE_PCM;
        end
        else if (!rbc_s2_q)
        begin
          high_frames_q <= 2'd0;
          if (low_frames_q != `PCS_STRAP_FRAMES)
            low_frames_q <= low_frames_q + 2'd1;
          else
            mode_q <= PCS_MODE_GCI;
        end
        else
        begin
          low_frames_q <= 2'd0;
          if (high_frames_q != `PCS_STRAP_FRAMES)
            high_frames_q <= high_frames_q + 2'd1;
          else
            mode_q <= PCS_MODE_IDL;
        end
      end
    end

  // ========================================================================
  // power guard: transmit released until two frames after power-up
  logic [1:0] guard_q;
  logic tx_enable_q;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      guard_q <= 2'd0;
      tx_enable_q <= 1'b0;
    end
    else
    begin
      if (!pwr_s2_q || standby_q)
        guard_q <= 2'd0;
      else if (frame_evt && guard_q != `PCS_GUARD_FRAMES)
        guard_q <= guard_q + 2'd1;
      tx_enable_q <= pwr_s2_q && !standby_q &&
        guard_q == `PCS_GUARD_FRAMES;
    end

  // ========================================================================
  // sample exchange with the companding unit, once per frame
  logic [7:0] tx_code_q, rx_code_q, rx_word_q, code_w;
  logic [15:0] rx_sample_q, lin_w;

  pcs_g711 u_g711
  (
    .law_mu(law_s2_q),
    .lin_in(tx_sample),
    .code_out(code_w),
    .code_in(rx_code_q),
    .lin_out(lin_w)
  );

  // words crossing here were settled by the end of their slot, before the next toggle
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      tx_code_q <= 8'hff;
      rx_code_q <= 8'hff;
      rx_sample_q <= 16'h0000;
    end
    else
    begin
      if (frame_evt)
      begin
        tx_code_q <= code_w;
        rx_code_q <= rx_word_q;
      end
      if (sample_strobe_q)
        rx_sample_q <= lin_w;
    end

  // ========================================================================
  // link domain on the transmit bit clock
  logic lrst_s1_q, lrst_n_q;
  logic en_s1_q, en_s2_q, b2_s1_q, b2_s2_q;
  logic [1:0] md_s1_q, md_s2_q;
  logic [5:0] fcnt_q;

  // local reset asserts at once and releases on the link clock
  always_ff @(negedge tx_bit_clock or negedge rst_n)
    if (!rst_n)
      {lrst_n_q, lrst_s1_q} <= 2'b00;
    else
      {lrst_n_q, lrst_s1_q} <= {lrst_s1_q, 1'b1};

  // quasi-static controls; mode is gray coded so one bit moves, except two bits between pcm and idl
  always_ff @(negedge tx_bit_clock or negedge lrst_n_q)
    if (!lrst_n_q)
    begin
      {en_s1_q, en_s2_q, b2_s1_q, b2_s2_q} <= 4'h0;
      {md_s1_q, md_s2_q} <= 4'h0;
    end
    else
    begin
      {en_s2_q, en_s1_q} <= {en_s1_q, tx_enable_q};
      {b2_s2_q, b2_s1_q} <= {b2_s1_q, active_b2_q};
      {md_s2_q, md_s1_q} <= {md_s1_q, mode_q};
    end

  // slot start and bit length per mode; gci bits last two clocks
  function automatic logic [5:0] slot_start(input logic [1:0] md,
    input logic b2);
    if (md == PCS_MODE_PCM || !b2)
      slot_start = `PCS_SLOT_B1;
    else if (md == PCS_MODE_IDL)
      slot_start = `PCS_SLOT_IDL_B2;
    else
      slot_start = `PCS_SLOT_GCI_B2;
  endfunction : slot_start

  logic [5:0] start_w, span_w, rel_w;
  logic gci_w, in_slot_w;
  assign gci_w = md_s2_q == PCS_MODE_GCI;
  assign start_w = slot_start(md_s2_q, b2_s2_q);
  assign span_w = gci_w ? 6'(`PCS_WORD_BITS << 1) : `PCS_WORD_BITS;
  assign rel_w = fcnt_q - start_w;
  assign in_slot_w = fcnt_q >= start_w && rel_w < span_w;

  // ========================================================================
  // falling edge: frame detect, long/short decision, receive shifter
  logic fs_prev_q, long_q, frame_go, tx_live_q;
  logic [7:0] rx_shift_q, tx_word_q;
  logic [2:0] rx_bits_q;

  // frame sync is synchronous with this clock, so no synchroniser
  assign frame_go = tx_frame_sync && !fs_prev_q;

  always_ff @(negedge tx_bit_clock or negedge lrst_n_q)
    if (!lrst_n_q)
    begin
      fs_prev_q <= 1'b0;
      long_q <= 1'b0;
      fcnt_q <= `PCS_FCNT_MAX;
      frame_tgl_q <= 1'b0;
      tx_word_q <= 8'hff;
    end
    else
    begin
      fs_prev_q <= tx_frame_sync;
      if (frame_go)
      begin
        fcnt_q <= 6'd0;
        frame_tgl_q <= ~frame_tgl_q;
        tx_word_q <= tx_code_q;
      end
      else if (fcnt_q != `PCS_FCNT_MAX)
        fcnt_q <= fcnt_q + 6'd1;
      if (fcnt_q == 6'd0 && !frame_go)
        long_q <= tx_frame_sync;
    end

  // enable only takes hold at a frame start, so no frame goes out cut;
  // a power-down still releases the pin at once
  always_ff @(negedge tx_bit_clock or negedge lrst_n_q)
    if (!lrst_n_q)
      tx_live_q <= 1'b0;
    else if (!en_s2_q)
      tx_live_q <= 1'b0;
    else if (frame_go)
      tx_live_q <= 1'b1;

  // receive bits are taken one falling edge after each transmit bit opens, in gci on the second falling edge
  always_ff @(negedge tx_bit_clock or negedge lrst_n_q)
    if (!lrst_n_q)
    begin
      rx_shift_q <= 8'hff;
      rx_bits_q <= 3'd0;
      rx_word_q <= 8'hff;
    end
    else if (frame_go)
      rx_bits_q <= 3'd0;
    else if (fcnt_q >= start_w && rel_w < span_w &&
      (!gci_w || rel_w[0]))
    begin
      rx_shift_q <= {rx_shift_q[6:0], serial_rx_data};
      rx_bits_q <= rx_bits_q + 3'd1;
      if (rx_bits_q == 3'd7)
        rx_word_q <= {rx_shift_q[6:0], serial_rx_data};
    end

  // ========================================================================
  // rising edge: transmit bit, msb first
  logic tx_bit_q, tx_en_q;
  logic [2:0] bit_idx_w;
  assign bit_idx_w = gci_w ? rel_w[3:1] : rel_w[2:0];

  always_ff @(posedge tx_bit_clock or negedge lrst_n_q)
    if (!lrst_n_q)
    begin
      tx_bit_q <= 1'b1;
      tx_en_q <= 1'b0;
    end
    else
    begin
      tx_en_q <= tx_live_q && en_s2_q && in_slot_w;
      tx_bit_q <= tx_word_q[3'd7 - bit_idx_w];
    end

  // drive drops at the falling edge inside the lsb's last clock, half way through that clock
  assign serial_tx_data = tx_bit_q;
  assign serial_tx_oe_n = !(tx_en_q && in_slot_w);

  assign sample_strobe = sample_strobe_q;
  assign rx_sample = rx_sample_q;
  assign frame_period = frame_period_q;
  assign mode = mode_q;
  assign active_b2 = active_b2_q;
  assign standby = standby_q;
  assign long_frame = long_q;

  // ========================================================================
  // checks
  guard_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tx_enable_q |-> $past(guard_q) == `PCS_GUARD_FRAMES && $past(pwr_s2_q))
    else $error("transmit enabled before two frames");
  gci_wait_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(mode_q) && mode_q == PCS_MODE_GCI |->
      $past(low_frames_q) == `PCS_STRAP_FRAMES && !$past(rbc_s2_q))
    else $error("gci entered too early");
  idl_wait_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(mode_q) && mode_q == PCS_MODE_IDL |->
      $past(high_frames_q) == `PCS_STRAP_FRAMES && $past(rbc_s2_q))
    else $error("idl entered without high strap");
  pcm_mode_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    frame_evt && rbc_seen_q |=> mode_q == PCS_MODE_PCM)
    else $error("toggling bit clock did not select pcm");
  strobe_lock_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    frame_evt |=> sample_strobe_q ##1 !sample_strobe_q)
    else $error("sample strobe not locked to frame");
  tx_word_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    frame_evt |=> tx_code_q == $past(code_w))
    else $error("transmit code not taken at frame");
  rx_expand_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    frame_evt ##1 1'b1 |=> rx_sample_q == $past(lin_w))
    else $error("received word not expanded");
  long_detect_a: assert property (
    @(negedge tx_bit_clock) disable iff (!lrst_n_q)
    frame_go ##1 tx_frame_sync |=> long_q)
    else $error("long frame sync not recognised");
  drive_window_a: assert property (
    @(posedge tx_bit_clock) disable iff (!lrst_n_q)
    !serial_tx_oe_n |-> en_s2_q || $past(en_s2_q))
    else $error("transmit driven while released");
endmodule : pcs_codec_serial

// File: verilog/pcs_consts.svh
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
// ==========================================================================
// timing
`define PCS_CLK_NS 8
`define PCS_FRAME_LOSS_NS 187500
`define PCS_FRAME_LOSS_CYC ((`PCS_FRAME_LOSS_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_GUARD_FRAMES 2'd2
`define PCS_STRAP_FRAMES 2'd2
// ==========================================================================
// slot layout, counted in bit clock falling edges after the frame edge
`define PCS_SLOT_B1 6'd0
`define PCS_SLOT_IDL_B2 6'd10
`define PCS_SLOT_GCI_B2 6'd16
`define PCS_FCNT_MAX 6'd63
`define PCS_WORD_BITS 6'd8
// ==========================================================================
// companding constants
`define PCS_MU_CLIP 14'd8159
`define PCS_MU_BIAS 14'd33
`define PCS_MU_MASK_POS 8'hff
`define PCS_MU_MASK_NEG 8'h7f
`define PCS_MU_DEC_BIAS 16'h0084
`define PCS_A_MASK_POS 8'hd5
`define PCS_A_MASK_NEG 8'h55
`define PCS_A_CLIP_CODE 8'h7f
`define PCS_A_SEG0_OFS 16'h0008
`define PCS_A_SEG1_OFS 16'h0108
`endif

// File: verilog/pcs_g711.sv
`include "pcs_consts.svh"
module pcs_g711
  import pcs_pkg::*;
(
  // law select, high for mu-law
  input wire logic law_mu,
  // compress path
  input wire logic [15:0] lin_in,
  output logic [7:0] code_out,
  // expand path
  input wire logic [7:0] code_in,
  output logic [15:0] lin_out
);
  // ========================================================================
  // mu-law compressor on the top 14 bits
  function automatic logic [7:0] mu_compress(input logic [15:0] lin);
    logic [13:0] m;
    logic [2:0] seg;
    logic [7:0] mask;
    logic [3:0] mant;
    m = lin[15:2];
    mask = lin[15] ? `PCS_MU_MASK_NEG : `PCS_MU_MASK_POS;
    if (lin[15])
      m = -m;
    // unsigned compare also clips the -8192 wrap
    if (m > `PCS_MU_CLIP)
      m = `PCS_MU_CLIP;
    m = m + `PCS_MU_BIAS;
    seg = 3'd7;
    for (int i = 7; i >= 0; i--)
      if (m <= 14'((32'h40 << i) - 1))
        seg = 3'(i);
    // biased full scale lands past segment 7: clip to its last step
    mant = m[13] ? 4'hf : 4'(m >> ({1'b0, seg} + 4'd1));
    mu_compress = {1'b0, seg, mant} ^ mask;
  endfunction : mu_compress

  // mu-law expander, 16-bit linear result
  function automatic logic [15:0] mu_expand(input logic [7:0] code);
    logic [7:0] u;
    logic [15:0] t;
    u = ~code;
    t = ({9'h000, u[3:0], 3'b000} + `PCS_MU_DEC_BIAS) << u[6:4];
    mu_expand = u[7] ? (`PCS_MU_DEC_BIAS - t) : (t - `PCS_MU_DEC_BIAS);
  endfunction : mu_expand

  // ========================================================================
  // a-law compressor on the top 13 bits
  function automatic logic [7:0] a_compress(input logic [15:0] lin);
    logic [12:0] p;
    logic [3:0] seg;
    logic [7:0] mask;
    logic [3:0] mant;
    p = lin[15:3];
    mask = lin[15] ? `PCS_A_MASK_NEG : `PCS_A_MASK_POS;
    if (lin[15])
      p = ~p;
    seg = 4'd8;
    for (int i = 7; i >= 0; i--)
      if (p <= 13'((32'h20 << i) - 1))
        seg = 4'(i);
    mant = (seg < 4'd2) ? 4'(p >> 1) : 4'(p >> seg);
    if (seg[3])
      a_compress = `PCS_A_CLIP_CODE ^ mask;
    else
      a_compress = {1'b0, seg[2:0], mant} ^ mask;
  endfunction : a_compress

  // a-law expander, 16-bit linear result
  function automatic logic [15:0] a_expand(input logic [7:0] code);
    logic [7:0] a;
    logic [15:0] t;
    a = code ^ `PCS_A_MASK_NEG;
    t = {8'h00, a[3:0], 4'h0};
    unique case (a[6:4])
      3'd0: t = t + `PCS_A_SEG0_OFS;
      3'd1: t = t + `PCS_A_SEG1_OFS;
      default: t = (t + `PCS_A_SEG1_OFS) << (a[6:4] - 3'd1);
    endcase
    a_expand = a[7] ? t : -t;
  endfunction : a_expand

  // one law pin steers both directions
  assign code_out = law_mu ? mu_compress(lin_in) : a_compress(lin_in);
  assign lin_out = law_mu ? mu_expand(code_in) : a_expand(code_in);
endmodule : pcs_g711

// File: verilog/pcs_pkg.sv
package pcs_pkg;
  // interface mode, gray coded along pcm -> gci -> idl
  typedef enum logic [1:0]
  {
    PCS_MODE_PCM = 2'b00,
    PCS_MODE_GCI = 2'b01,
    PCS_MODE_IDL = 2'b11
  } pcs_mode_t;
endpackage : pcs_pkg
